//--- logic/rxo_channel.sv
// Purpose: receive output stage of one channel
// Assumes: link pins sampled on mclk; data stable around link edge
// Notes:   one instance per receive channel
// Function
// - Twelve output signals: data, flag, parity
// - Framed character sits in output register
// - Flag high only on framing character, outside self-test
// - Low latency half rate stretches clock
// - Other framer half rate shifts pipeline
// - Alignment only while framer enabled
// - Parity is always odd
// - Parity select low floats parity pin
// - Mid select covers ten data bits
// - High select adds the framing flag
// - Parity and flag share output register
// - Self-test shows state on flag, bits
// - Lost lock forces start state
// - Seventeenth net error goes to wait
// - Buffer fault holds start while recentring
// - Last good or bad lasts one character
// - Status codes follow fixed encoding
`timescale 1ns/100ps
`include "rxo_regs.svh"
module rxo_channel
  import rxo_pkg::*;
#(
  parameter int DEPTH = `RXO_FIFO_DEPTH
)(
  input  logic                   mclk,
  input  logic                   reset_n,
  input  logic                   rec_clk,
  input  logic [`RXO_CHAR_W-1:0] char_in,
  input  logic                   frame_hit_in,
  input  logic                   cmp_ok_in,
  input  logic                   cmp_cmd_in,
  input  logic                   cmp_last_in,
  input  logic                   seq_start_in,
  input  logic                   framer_enable,
  input  logic                   framer_mode_sel,
  input  logic                   rx_half_rate_sel,
  input  logic [1:0]             parity_mode_sel,
  input  logic                   selftest_en,
  input  logic                   pll_locked,
  input  logic                   ebuf_fault,
  output logic [`RXO_CHAR_W-1:0] rx_char_bus,
  output logic                   frame_match_flag,
  output logic                   rx_parity_out,
  output logic                   rx_parity_oe,
  output logic                   rx_out_clk_true,
  output logic                   rx_out_clk_comp,
  output logic                   fifo_overrun
);
  localparam int SW = `RXO_WORD_W + 9;
  localparam logic [2:0] STRETCH = 3'(`RXO_STRETCH_CYC);

  logic [SW-1:0]          async_in;
  logic [SW-1:0]          sync1;
  logic [SW-1:0]          sync2;
  logic [`RXO_WORD_W-1:0] word_s;
  logic                   rec_s;
  logic                   rec_q;
  logic                   fe_s;
  logic                   mode_s;
  logic                   half_s;
  logic [1:0]             par_s;
  logic                   sten_s;
  logic                   pll_s;
  logic                   fault_s;
  logic                   rise;
  logic                   f_in_ready;
  logic                   f_valid;
  logic                   f_ready;
  logic [`RXO_WORD_W-1:0] cur;
  logic [`RXO_WORD_W-1:0] dly;
  logic [`RXO_WORD_W-1:0] cand;
  logic                   upd;
  logic                   align;
  logic                   stretch;
  logic                   sel_dly;
  logic                   next_sel;
  logic [2:0]             rise_cnt;
  rxo_st_t                st;
  rxo_st_t                next_st;
  logic [4:0]             diff;
  logic [4:0]             next_diff;
  logic [3:0]             recenter;
  logic [`RXO_CHAR_W-1:0] next_data;
  logic                   next_flag;
  logic                   next_par;
  logic                   upd_q;
  logic                   aln_q;
  logic                   miss_evt;

  // Odd parity bit: a zero bit leaves the result alone
  function automatic logic odd_bit(input logic [`RXO_CHAR_W:0] v);
    odd_bit = ~(^v);
  endfunction

  // Every pin except mclk and reset_n crosses two flops before use
  assign async_in = {seq_start_in, cmp_last_in, cmp_cmd_in, cmp_ok_in,
                     frame_hit_in, char_in, rec_clk, framer_enable,
                     framer_mode_sel, rx_half_rate_sel, parity_mode_sel,
                     selftest_en, pll_locked, ebuf_fault};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= async_in;
      sync2 <= sync1;
    end
  end

  assign word_s  = sync2[SW-1:9];
  assign rec_s   = sync2[8];
  assign fe_s    = sync2[7];
  assign mode_s  = sync2[6];
  assign half_s  = sync2[5];
  assign par_s   = sync2[4:3];
  assign sten_s  = sync2[2];
  assign pll_s   = sync2[1];
  assign fault_s = sync2[0];

  // Link edge finder, reads only the second stage
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rec_q <= 1'b0;
    end
    else
    begin
      rec_q <= rec_s;
    end
  end

  assign rise = rec_s & ~rec_q;

  // Buffer absorbs clock stretching; draining stalls while it runs
  rxo_fifo #(
    .WIDTH (`RXO_WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (rise),
    .in_ready  (f_in_ready),
    .in_data   (word_s),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (cur)
  );

  assign f_ready = (rise_cnt == 3'h0);
  assign upd     = f_valid & f_ready;

  // Sticky: a character was lost because the buffer was full
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fifo_overrun <= 1'b0;
    end
    else if (rise && !f_in_ready)
    begin
      fifo_overrun <= 1'b1;
    end
  end

  // Boundary choice; fixed whenever the framer is off
  always_comb
  begin
    align    = fe_s & half_s;
    next_sel = align ? sel_dly : 1'b0;
    if (align && mode_s && cur[`RXO_F_HIT])
    begin
      next_sel = rx_out_clk_true;
    end
    cand    = next_sel ? dly : cur;
    stretch = align & ~mode_s & cand[`RXO_F_HIT] & rx_out_clk_true;
  end

  // Output clock: full rate pulses, half rate toggles
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_out_clk_true <= 1'b0;
      rise_cnt        <= 3'h0;
    end
    else if (upd)
    begin
      if (!half_s)
      begin
        rx_out_clk_true <= 1'b0;
        rise_cnt        <= 3'h1;
      end
      else if (stretch)
      begin
        rx_out_clk_true <= 1'b0;
        rise_cnt        <= STRETCH;
      end
      else
      begin
        rx_out_clk_true <= ~rx_out_clk_true;
      end
    end
    else if (rise_cnt != 3'h0)
    begin
      rise_cnt <= rise_cnt - 3'h1;
      if (rise_cnt == 3'h1)
      begin
        rx_out_clk_true <= 1'b1;
      end
    end
  end

  assign rx_out_clk_comp = ~rx_out_clk_true;

  // Recentring window after a buffer fault
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      recenter <= 4'h0;
    end
    else if (fault_s)
    begin
      recenter <= `RXO_RECENTER_CHARS;
    end
    else if (upd && recenter != 4'h0)
    begin
      recenter <= recenter - 4'h1;
    end
  end

  // Self-test state, stepped once per character
  always_comb
  begin
    next_st   = st;
    next_diff = diff;
    miss_evt  = 1'b0;
    if (upd)
    begin
      case (st)
        rxo_st_start:
        begin
          next_st = rxo_st_wait;
        end
        rxo_st_wait, rxo_st_good, rxo_st_bad:
        begin
          next_st   = cand[`RXO_F_D00] ? rxo_st_data : rxo_st_wait;
          next_diff = 5'h0;
        end
        default:
        begin
          if (!cand[`RXO_F_OK])
          begin
            miss_evt = 1'b1;
            if (diff >= `RXO_ERR_LIMIT)
            begin
              next_st   = rxo_st_wait;
              next_diff = 5'h0;
            end
            else
            begin
              next_st   = cand[`RXO_F_LAST] ? rxo_st_bad : rxo_st_err;
              next_diff = diff + 5'h1;
            end
          end
          else
          begin
            next_diff = (diff == 5'h0) ? 5'h0 : diff - 5'h1;
            if (cand[`RXO_F_LAST])
            begin
              next_st = rxo_st_good;
            end
            else
            begin
              next_st = cand[`RXO_F_CMD] ? rxo_st_cmd : rxo_st_data;
            end
          end
        end
      endcase
    end
    // Forcing wins over any step, in any state
    if (!sten_s || !pll_s || fault_s || recenter != 4'h0)
    begin
      next_st   = rxo_st_start;
      next_diff = 5'h0;
    end
  end

  // Channel-local state, nothing shared between channels
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st   <= rxo_st_start;
      diff <= 5'h0;
    end
    else
    begin
      st   <= next_st;
      diff <= next_diff;
    end
  end

  // Presented values; status replaces flag and two low bits
  always_comb
  begin
    next_data = cand[`RXO_CHAR_W-1:0];
    next_flag = cand[`RXO_F_HIT];
    if (sten_s)
    begin
      next_data[1:0] = {next_st[0], next_st[1]};
      next_flag      = next_st[2];
    end
    next_par = odd_bit({next_flag & (par_s == rxo_par_high), next_data});
  end

  // One output register for data, flag and parity
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_char_bus      <= '0;
      frame_match_flag <= 1'b0;
      rx_parity_out    <= 1'b1;
      dly              <= '0;
      sel_dly          <= 1'b0;
    end
    else if (upd)
    begin
      rx_char_bus      <= next_data;
      frame_match_flag <= next_flag;
      rx_parity_out    <= next_par;
      dly              <= cur;
      sel_dly          <= next_sel;
    end
  end

  // Pin driver enable; the pad floats when low
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_parity_oe <= 1'b0;
    end
    else
    begin
      rx_parity_oe <= (par_s != rxo_par_low);
    end
  end

  // Helpers that only the checks read
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      upd_q <= 1'b0;
      aln_q <= 1'b0;
    end
    else
    begin
      upd_q <= upd;
      aln_q <= upd & align & ~sten_s;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence seq_fault_end;
    fault_s ##1 !fault_s;
  endsequence

  sequence seq_hit_shown;
    upd_q && aln_q && frame_match_flag;
  endsequence

  chk_parity_mid: assert property (
    upd && par_s == rxo_par_mid |=> (^{rx_char_bus, rx_parity_out}) == 1'b1)
    else $error("mid parity not odd over data");

  chk_parity_high: assert property (
    upd && par_s == rxo_par_high
    |=> (^{frame_match_flag, rx_char_bus, rx_parity_out}) == 1'b1)
    else $error("high parity not odd over data and flag");

  chk_parity_float: assert property (
    par_s == rxo_par_low ##1 par_s == rxo_par_low |-> !rx_parity_oe)
    else $error("parity pin driven in low mode");

  chk_lock_start: assert property (
    !pll_s |=> st == rxo_st_start)
    else $error("lost lock did not force start");

  chk_fault_hold: assert property (
    seq_fault_end |-> st == rxo_st_start [*2])
    else $error("start not held after buffer fault");

  chk_err_wait: assert property (
    miss_evt && diff == `RXO_ERR_LIMIT && sten_s && pll_s && !fault_s
    && recenter == 4'h0 |=> st == rxo_st_wait)
    else $error("error excess did not go to wait");

  chk_last_once: assert property (
    upd && (st == rxo_st_good || st == rxo_st_bad)
    |=> st != rxo_st_good && st != rxo_st_bad)
    else $error("last status held over a character");

  chk_status_map: assert property (
    upd && sten_s
    |=> frame_match_flag == st[2] && rx_char_bus[1:0] == {st[0], st[1]})
    else $error("status not shown on flag and low bits");

  chk_hit_edge: assert property (
    seq_hit_shown |-> ##[0:3] rx_out_clk_true)
    else $error("true clock not high with framing flag");
endmodule

//--- logic/rxo_regs.svh
// Purpose: constants of the receive output stage
// Assumes: included by its bare name
// Notes:   word fields are bit positions in the buffered word
`ifndef RXO_REGS_SVH
`define RXO_REGS_SVH
`define RXO_CHAR_W         10
`define RXO_WORD_W         15
`define RXO_FIFO_DEPTH     8
`define RXO_F_HIT          10
`define RXO_F_OK           11
`define RXO_F_CMD          12
`define RXO_F_LAST         13
`define RXO_F_D00          14
`define RXO_ERR_LIMIT      5'h10
`define RXO_RECENTER_CHARS 4'h9
`define RXO_CLK_MHZ        20
`define RXO_STRETCH_NS     100
`define RXO_STRETCH_CYC    ((`RXO_STRETCH_NS * `RXO_CLK_MHZ + 999) / 1000)
`endif

//--- logic/rxo_pkg.sv
// Purpose: types of the receive output stage
// Assumes: nothing
// Notes:   state codes equal the shown status {flag, bit0, bit1}
package rxo_pkg;
  typedef enum logic [2:0] {
    rxo_st_data  = 3'b000,
    rxo_st_cmd   = 3'b001,
    rxo_st_good  = 3'b010,
    rxo_st_bad   = 3'b100,
    rxo_st_start = 3'b101,
    rxo_st_err   = 3'b110,
    rxo_st_wait  = 3'b111
  } rxo_st_t;
  typedef enum logic [1:0] {
    rxo_par_low  = 2'b00,
    rxo_par_mid  = 2'b10,
    rxo_par_high = 2'b11
  } rxo_par_t;
endpackage

//--- logic/rxo_fifo.sv
// Purpose: small word FIFO between link sampling and output register
// Assumes: single clock, valid/ready on both sides
// Notes:   full shows as in_ready low
`timescale 1ns/100ps
module rxo_fifo
#(
  parameter int WIDTH = 15,
  parameter int DEPTH = 8
)(
  input  logic             mclk,
  input  logic             reset_n,
  input  logic             in_valid,
  output logic             in_ready,
  input  logic [WIDTH-1:0] in_data,
  output logic             out_valid,
  input  logic             out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  // Wrap works for any depth, not only powers of two
  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Honest flags from the fill count
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage, no reset needed for data
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop)
      begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop)
      begin
        count <= count + 1'b1;
      end
      else if (pop && !push)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

//--- tb/rxo_host_model.sv
// Purpose: host logic capturing one channel's receive bus
// Assumes: bus settled by just after the true output clock rises
// Notes:   parity pin floats whenever the channel releases it
`timescale 1ns/100ps
module rxo_host_model
(
  input  logic       clk_true,
  input  logic [9:0] bus,
  input  logic       flag,
  input  logic       par,
  input  logic       par_oe,
  output logic [9:0] cap_bus,
  output logic       cap_flag,
  output logic       cap_par
);
  wire par_pin;

  // Released pin reads as high impedance, never the last value
  assign par_pin = par_oe ? par : 1'hZ;

  // Sample just after the rise: half rate launches data and clock together
  always @(posedge clk_true)
  begin
    #1;
    cap_bus  <= bus;
    cap_flag <= flag;
    cap_par  <= par_pin;
  end
endmodule

//--- tb/testbench.sv
// Purpose: self-checking bench for one receive output channel
// Assumes: framer on until the last character of the last test, one char per 400 ns link period; half rate runs last
// Notes:   results judged through the host capture model and direct output probes
`timescale 1ns/100ps
module testbench;
  import rxo_pkg::*;
  logic       mclk, reset_n, rec_clk, frame_hit_in, cmp_ok_in, cmp_cmd_in;
  logic       cmp_last_in, seq_start_in, framer_enable, framer_mode_sel;
  logic       rx_half_rate_sel, selftest_en, pll_locked, ebuf_fault;
  logic [9:0] char_in, rx_char_bus, cap_bus;
  logic [1:0] parity_mode_sel;
  logic       frame_match_flag, rx_parity_out, rx_parity_oe, rx_out_clk_true;
  logic       rx_out_clk_comp, fifo_overrun, cap_flag, cap_par;
  int         error_cnt, n_compared;

  rxo_channel #(.DEPTH(8)) dut (.mclk(mclk), .reset_n(reset_n), .rec_clk(rec_clk),
    .char_in(char_in), .frame_hit_in(frame_hit_in), .cmp_ok_in(cmp_ok_in),
    .cmp_cmd_in(cmp_cmd_in), .cmp_last_in(cmp_last_in), .seq_start_in(seq_start_in),
    .framer_enable(framer_enable), .framer_mode_sel(framer_mode_sel),
    .rx_half_rate_sel(rx_half_rate_sel), .parity_mode_sel(parity_mode_sel),
    .selftest_en(selftest_en), .pll_locked(pll_locked), .ebuf_fault(ebuf_fault),
    .rx_char_bus(rx_char_bus), .frame_match_flag(frame_match_flag),
    .rx_parity_out(rx_parity_out), .rx_parity_oe(rx_parity_oe),
    .rx_out_clk_true(rx_out_clk_true), .rx_out_clk_comp(rx_out_clk_comp),
    .fifo_overrun(fifo_overrun));

  rxo_host_model host (.clk_true(rx_out_clk_true), .bus(rx_char_bus),
    .flag(frame_match_flag), .par(rx_parity_out), .par_oe(rx_parity_oe),
    .cap_bus(cap_bus), .cap_flag(cap_flag), .cap_par(cap_par));

  // System clock, 50 ns period
  initial
  begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic cmp(input string name, input logic [9:0] exp, input logic [9:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Status as {flag, bit0, bit1}
  task automatic chk_st(input string name, input logic [2:0] st);
    cmp(name, {7'h0, st}, {7'h0, cap_flag, cap_bus[0], cap_bus[1]});
  endtask

  // One link char; f = {hit, ok, cmd, last, start}; data scrambled after hold
  task automatic send(input logic [9:0] c, input logic [4:0] f);
    @(negedge mclk);
    char_in = c;
    {frame_hit_in, cmp_ok_in, cmp_cmd_in, cmp_last_in, seq_start_in} = f;
    rec_clk = 1'h1;
    repeat (4) @(negedge mclk);
    rec_clk = 1'h0;
    repeat (2) @(negedge mclk);
    char_in = ~c;
    repeat (1) @(negedge mclk);
  endtask

  task automatic t_data;
    logic [9:0] v [3];
    v = '{10'h2A5, 10'h000, 10'h3FF};
    parity_mode_sel = rxo_par_mid;
    foreach (v[i])
    begin
      send(v[i], 5'h00);
      cmp("bus", v[i], cap_bus);
      cmp("flag", 10'h000, {9'h0, cap_flag});
      cmp("parity mid", {9'h0, ~^v[i]}, {9'h0, cap_par});
    end
    $display("t_data done");
  endtask

  task automatic t_parity;
    parity_mode_sel = rxo_par_high;
    send(10'h17C, 5'h10);
    cmp("flag hit", 10'h001, {9'h0, cap_flag});
    cmp("parity high", {9'h0, ~^{1'h1, 10'h17C}}, {9'h0, cap_par});
    send(10'h17C, 5'h00);
    cmp("flag miss", 10'h000, {9'h0, cap_flag});
    cmp("parity odd", {9'h0, ~^10'h17C}, {9'h0, cap_par});
    parity_mode_sel = rxo_par_low;
    repeat (5) @(negedge mclk);
    cmp("parity oe", 10'h000, {9'h0, rx_parity_oe});
    send(10'h0F0, 5'h00);
    cmp("parity pin", 10'h000, {9'h0, cap_par === 1'hZ});
    $display("t_parity done");
  endtask

  task automatic t_selftest;
    parity_mode_sel = rxo_par_mid;
    selftest_en = 1'h1;
    pll_locked = 1'h0;
    send(10'h155, 5'h00);
    chk_st("unlocked", 3'h5);
    pll_locked = 1'h1;
    send(10'h155, 5'h00);
    chk_st("wait", 3'h7);
    send(10'h000, 5'h01);
    chk_st("seq start", 3'h0);
    send(10'h0AA, 5'h0C);
    chk_st("cmd", 3'h1);
    send(10'h0AA, 5'h0A);
    chk_st("last good", 3'h2);
    send(10'h0AA, 5'h08);
    chk_st("after last", 3'h7);
    send(10'h000, 5'h01);
    // Sixteen net misses are tolerated, the next one aborts
    for (int i = 0; i < 17; i++)
    begin
      send(10'h0AA, 5'h00);
      chk_st("miss", (i < 16) ? 3'h6 : 3'h7);
    end
    ebuf_fault = 1'h1;
    send(10'h000, 5'h01);
    chk_st("buffer fault", 3'h5);
    ebuf_fault = 1'h0;
    send(10'h000, 5'h01);
    chk_st("recentring", 3'h5);
    // Nine characters of start after the fault, then normal stepping
    for (int i = 0; i < 8; i++)
    begin
      send(10'h000, 5'h01);
      chk_st("recentring", 3'h5);
    end
    send(10'h000, 5'h01);
    chk_st("recentred", 3'h7);
    cmp("overrun", 10'h000, {9'h0, fifo_overrun});
    $display("t_selftest done");
  endtask

  // Half rate: toggle, stretch, pipeline shift, then framer off
  task automatic t_halfrate;
    selftest_en = 1'h0;
    rx_half_rate_sel = 1'h1;
    send(10'h111, 5'h00);
    send(10'h17C, 5'h10);
    cmp("hr hit bus", 10'h17C, cap_bus);
    cmp("hr hit flag", 10'h001, {9'h0, cap_flag});
    // Hit on the high phase: without a stretch the host misses it
    send(10'h283, 5'h10);
    cmp("stretch bus", 10'h283, cap_bus);
    cmp("stretch flag", 10'h001, {9'h0, cap_flag});
    framer_mode_sel = 1'h1;
    send(10'h0F0, 5'h00);
    send(10'h30F, 5'h00);
    send(10'h17C, 5'h10);
    cmp("stage added", 10'h30F, rx_char_bus);
    send(10'h055, 5'h00);
    cmp("shift bus", 10'h17C, cap_bus);
    cmp("shift flag", 10'h001, {9'h0, cap_flag});
    // Framer off: flag may sit on the complement clock's rise
    framer_enable = 1'h0;
    framer_mode_sel = 1'h0;
    send(10'h283, 5'h10);
    cmp("fixed flag", 10'h001, {9'h0, frame_match_flag});
    cmp("fixed clk", 10'h000, {9'h0, rx_out_clk_true});
    cmp("clk comp", 10'h001, {9'h0, rx_out_clk_comp});
    $display("t_halfrate done");
  endtask

  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence; framer settings change only in the last test
  initial
  begin
    {rec_clk, frame_hit_in, cmp_ok_in, cmp_cmd_in, cmp_last_in} = 5'h00;
    {seq_start_in, selftest_en, ebuf_fault, framer_mode_sel, rx_half_rate_sel} = 5'h00;
    framer_enable = 1'h1;
    pll_locked = 1'h1;
    char_in = 10'h000;
    parity_mode_sel = rxo_par_mid;
    error_cnt = 0;
    n_compared = 0;
    reset_n = 1'h0;
    repeat (12) @(negedge mclk);
    reset_n = 1'h1;
    repeat (2) @(negedge mclk);
    t_data();
    t_parity();
    t_selftest();
    t_halfrate();
    wrap_up();
  end

  // Tests need about 410 cycles; far beyond means a hang
  initial
  begin
    repeat (5000) @(posedge mclk);
    error_cnt++;
    wrap_up();
  end
endmodule
